// *** core/fcfc_codec.sv ***
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "fcfc_cfg.svh"

module fcfc_fifo #(
	parameter int W = `FC_E_W,
	parameter int D = `FC_FIFO_D
) (
	input  wire logic                 mclk,
	input  wire logic                 srst,
	input  wire logic                 inValid,
	output logic                      inReady,
	input  wire logic [W-1:0]         inData,
	output logic                      outValid,
	input  wire logic                 outReady,
	output logic [W-1:0]              outData,
	output logic [$clog2(D+1)-1:0]    level
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic          push;
	logic          pop;

	assign inReady  = level != ($clog2(D+1))'(D);
	assign outValid = level != '0;
	assign outData  = mem[rp];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wp] <= inData;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			wp    <= '0;
			rp    <= '0;
			level <= '0;
		end else begin
			if (push) begin
				wp <= (wp == AW'(D-1)) ? '0 : AW'(wp + 1'b1);
			end
			if (pop) begin
				rp <= (rp == AW'(D-1)) ? '0 : AW'(rp + 1'b1);
			end
			if (push && !pop) begin
				level <= ($clog2(D+1))'(level + 1'b1);
			end else if (pop && !push) begin
				level <= ($clog2(D+1))'(level - 1'b1);
			end
		end
	end
endmodule // fcfc_fifo

// How it works
// - 300 bps FSK, 1850 Hz zero, 1650 Hz one
// - frame opens with 8-bit identification code
// - DIS and DCS carry appended field bits
// - DIS identification code is 00000001
// - DCS code X1000001, top bit ignored
// - receiver announces its capabilities by DIS
// - bits 1-5 T.2/T.3 flags, 6-8 reserved
// - bit 9 T.4 transmit, bit 10 receive
// - DIS bits 11-12 give supported modem rates
// - DCS bits 11-12 select signalling rate
// - bits 13-14 reserved modulation, no meaning
// - bit 15 fine resolution, 16 2-D coding
// - DIS width bits 17-18, 11 invalid
// - DCS width bits 17-18 select line width
// - length bits 19-20, 11 invalid
module fcfc_codec import fcfc_pkg::*; #(
	parameter int BIT_CYCLES = `FC_CLK_HZ / `FC_BAUD,
	parameter int HALF0      = `FC_CLK_HZ / (2 * `FC_TONE0_HZ),
	parameter int HALF1      = `FC_CLK_HZ / (2 * `FC_TONE1_HZ),
	parameter int FIFO_D     = `FC_FIFO_D
) (
	input  wire logic                 mclk,
	input  wire logic                 srst,
	input  wire logic [7:0]           paddr,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [31:0]          pwdata,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	output logic                      txFsk,
	output logic                      txBit,
	output logic                      txActive,
	input  wire logic                 rxBit,
	input  wire logic                 rxValid,
	input  wire logic                 rxFrame,
	output logic                      rxReady,
	output logic [1:0]                modeRate,
	output logic [1:0]                modeWidth,
	output logic [1:0]                modeLength,
	output logic                      modeFine,
	output logic                      mode2d,
	output logic                      modeT4Rx,
	output logic                      modeValid,
	output logic [`FC_FLD_W-1:0]      capFlags
);
	localparam int FW = `FC_FRM_W;
	localparam int LW = $clog2(FIFO_D+1);

	fcfc_tx_t                txState;
	fcfc_rx_t                rxState;
	logic                    ctrlDcs;
	logic                    goReq;
	logic [`FC_FLD_W-1:0]    txField;
	logic [`FC_FLD_W-1:0]    txFldClean;
	logic [`FC_FLD_W-1:0]    txFldRev;
	logic [`FC_FLD_W-1:0]    txShiftFld;
	logic [FW-1:0]           txLoad;
	logic [FW-1:0]           txShift;
	logic [`FC_LEFT_W-1:0]   txLeft;
	logic [`FC_CNT_W-1:0]    bitCnt;
	logic                    bitTick;
	logic [`FC_CNT_W-1:0]    toneCnt;
	logic [`FC_CNT_W-1:0]    toneHalf;
	logic [FW-1:0]           rxShift;
	logic [FW-1:0]           next_rxShift;
	logic [`FC_LEFT_W-1:0]   rxCnt;
	logic [`FC_E_W-1:0]      rxEntry;
	logic                    take;
	logic [`FC_ID_W-1:0]     hdrId;
	logic [`FC_ID_W-1:0]     rxId;
	logic [`FC_FLD_W-1:0]    rxFldRaw;
	logic [`FC_FLD_W-1:0]    rxFld;
	logic [1:0]              rxWidth;
	logic [1:0]              rxLength;
	logic                    rxErr;
	fcfc_kind_t              hdrKind;
	fcfc_kind_t              rxKind;
	logic                    fieldDone;
	logic                    errSticky;
	logic                    fifoInReady;
	logic                    fifoAvail;
	logic [`FC_E_W-1:0]      fifoHead;
	logic [LW-1:0]           fifoLevel;
	logic                    apbSetup;
	logic                    apbAccess;
	logic                    apbMapped;
	logic                    popReq;
	logic [31:0]             rdMux;

	// ---- transmit framing
	assign txFldClean = txField & ~`FC_RSV_BITS;
	assign txFldRev   = {<<{txFldClean}}; // field bit 1 goes first
	assign txLoad     = {ctrlDcs ? `FC_ID_DCS : `FC_ID_DIS, txFldRev};
	assign txShiftFld = {<<{txShift[`FC_FLD_W-1:0]}};

	always_ff @(posedge mclk) begin
		if (srst) begin
			txState  <= TX_IDLE;
			txShift  <= '0;
			txLeft   <= '0;
			txBit    <= 1'b0;
			txActive <= 1'b0;
		end else begin
			unique case (txState)
				TX_IDLE: begin
					if (goReq) begin
						txShift  <= txLoad;
						txLeft   <= `FC_LEFT_W'(FW-1);
						txBit    <= txLoad[FW-1];
						txActive <= 1'b1;
						txState  <= TX_SEND;
					end
				end
				TX_SEND: begin
					if (bitTick) begin
						if (txLeft == '0) begin
							txActive <= 1'b0;
							txBit    <= 1'b0;
							txState  <= TX_IDLE;
						end else begin
							txShift <= {txShift[FW-2:0], 1'b0};
							txBit   <= txShift[FW-2];
							txLeft  <= `FC_LEFT_W'(txLeft - 1'b1);
						end
					end
				end
			endcase
		end
	end

	// baud divider, one tick per bit time
	always_ff @(posedge mclk) begin
		if (srst || !txActive) begin
			bitCnt  <= '0;
			bitTick <= 1'b0;
		end else if (bitCnt == `FC_CNT_W'(BIT_CYCLES-1)) begin
			bitCnt  <= '0;
			bitTick <= 1'b1;
		end else begin
			bitCnt  <= `FC_CNT_W'(bitCnt + 1'b1);
			bitTick <= 1'b0;
		end
	end

	// square-wave tone, half period picked by the bit value
	assign toneHalf = txBit ? `FC_CNT_W'(HALF1-1) : `FC_CNT_W'(HALF0-1);

	always_ff @(posedge mclk) begin
		if (srst || !txActive) begin
			toneCnt <= '0;
			txFsk   <= 1'b0;
		end else if (toneCnt >= toneHalf) begin
			toneCnt <= '0;
			txFsk   <= ~txFsk;
		end else begin
			toneCnt <= `FC_CNT_W'(toneCnt + 1'b1);
		end
	end

	// ---- receive parsing
	assign take         = rxValid && rxReady && rxFrame;
	assign next_rxShift = {rxShift[FW-2:0], rxBit};
	assign hdrId        = next_rxShift[`FC_ID_W-1:0];
	assign rxId         = next_rxShift[FW-1:`FC_FLD_W];
	assign rxFldRaw     = {<<{next_rxShift[`FC_FLD_W-1:0]}};
	assign rxFld        = rxFldRaw & ~`FC_RSV_BITS;
	// first field bit of a pair is the code's msb
	assign rxWidth      = {rxFld[`FC_FB_WIDTH], rxFld[`FC_FB_WIDTH+1]};
	assign rxLength     = {rxFld[`FC_FB_LEN], rxFld[`FC_FB_LEN+1]};
	assign rxErr        = (rxWidth == `FC_CODE_BAD) || (rxLength == `FC_CODE_BAD);

	always_comb begin
		hdrKind = FK_OTHER;
		if (hdrId == `FC_ID_DIS) begin
			hdrKind = FK_DIS;
		end else if ((hdrId & `FC_DCS_CARE) == (`FC_ID_DCS & `FC_DCS_CARE)) begin
			hdrKind = FK_DCS;
		end
	end

	always_comb begin
		rxKind = FK_OTHER;
		if (rxId == `FC_ID_DIS) begin
			rxKind = FK_DIS;
		end else if ((rxId & `FC_DCS_CARE) == (`FC_ID_DCS & `FC_DCS_CARE)) begin
			rxKind = FK_DCS;
		end
	end

	assign fieldDone = (rxState == RX_FIELD) && take && (rxCnt == `FC_LEFT_W'(FW-1));

	always_ff @(posedge mclk) begin
		if (srst) begin
			rxState <= RX_HUNT;
			rxCnt   <= '0;
			rxShift <= '0;
			rxEntry <= '0;
			rxReady <= 1'b1;
		end else if (!rxFrame && rxState != RX_HOLD) begin
			rxState <= RX_HUNT;
			rxCnt   <= '0;
		end else begin
			unique case (rxState)
				RX_HUNT: begin
					if (take) begin
						rxShift <= next_rxShift;
						rxCnt   <= `FC_LEFT_W'(rxCnt + 1'b1);
						if (rxCnt == `FC_LEFT_W'(`FC_ID_W-1)) begin
							if (hdrKind != FK_OTHER) begin
								rxState <= RX_FIELD;
							end else begin
								rxEntry <= {1'b0, FK_OTHER, `FC_FLD_W'(0), hdrId};
								rxCnt   <= '0;
								rxReady <= 1'b0;
								rxState <= RX_HOLD;
							end
						end
					end
				end
				RX_FIELD: begin
					if (take) begin
						rxShift <= next_rxShift;
						rxCnt   <= `FC_LEFT_W'(rxCnt + 1'b1);
						if (fieldDone) begin
							rxEntry <= {rxErr, rxKind, rxFld, rxId};
							rxCnt   <= '0;
							rxReady <= 1'b0;
							rxState <= RX_HOLD;
						end
					end
				end
				RX_HOLD: begin
					if (fifoInReady) begin
						rxReady <= 1'b1;
						rxState <= RX_HUNT;
					end
				end
			endcase
		end
	end

	// a bad width or length keeps the last good settings
	always_ff @(posedge mclk) begin
		if (srst) begin
			modeRate   <= '0;
			modeWidth  <= '0;
			modeLength <= '0;
			modeFine   <= 1'b0;
			mode2d     <= 1'b0;
			modeT4Rx   <= 1'b0;
			modeValid  <= 1'b0;
		end else if (fieldDone && !rxErr && rxKind == FK_DCS) begin
			modeRate   <= {rxFld[`FC_FB_RATE], rxFld[`FC_FB_RATE+1]};
			modeWidth  <= rxWidth;
			modeLength <= rxLength;
			modeFine   <= rxFld[`FC_FB_FINE];
			mode2d     <= rxFld[`FC_FB_2D];
			modeT4Rx   <= rxFld[`FC_FB_T4RX];
			modeValid  <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			capFlags <= '0;
		end else if (fieldDone && !rxErr && rxKind == FK_DIS) begin
			capFlags <= rxFld;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			errSticky <= 1'b0;
		end else if (fieldDone && rxErr) begin
			errSticky <= 1'b1;
		end else if (apbAccess && pwrite && paddr == `FC_A_STAT && pwdata[`FC_ST_ERR]) begin
			errSticky <= 1'b0;
		end
	end

	fcfc_fifo #(
		.W (`FC_E_W),
		.D (FIFO_D)
	) u_fifo (
		.mclk     (mclk),
		.srst     (srst),
		.inValid  (rxState == RX_HOLD),
		.inReady  (fifoInReady),
		.inData   (rxEntry),
		.outValid (fifoAvail),
		.outReady (popReq),
		.outData  (fifoHead),
		.level    (fifoLevel)
	);

	// ---- APB slave, zero wait states
	assign apbSetup  = psel && !penable;
	assign apbAccess = psel && penable && pready;
	assign popReq    = apbAccess && !pwrite && paddr == `FC_A_RXFIFO;

	always_comb begin
		apbMapped = 1'b1;
		rdMux     = '0;
		unique case (paddr)
			`FC_A_CTRL: rdMux[`FC_CTRL_DCS] = ctrlDcs;
			`FC_A_TXFLD: rdMux = 32'(txField);
			`FC_A_STAT: begin
				rdMux[`FC_ST_BUSY]  = txActive;
				rdMux[`FC_ST_AVAIL] = fifoAvail;
				rdMux[`FC_ST_ERR]   = errSticky;
				rdMux[`FC_ST_LVL +: LW] = fifoLevel;
			end
			`FC_A_RXFIFO: begin
				rdMux[`FC_E_W-1:0]  = fifoAvail ? fifoHead : '0;
				rdMux[`FC_E_VALID]  = fifoAvail;
			end
			`FC_A_MODE: rdMux = 32'({modeValid, modeT4Rx, mode2d, modeFine, modeLength, modeWidth, modeRate});
			`FC_A_RCAP: rdMux = 32'(capFlags);
			default: apbMapped = 1'b0;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= apbSetup;
			pslverr <= apbSetup && !apbMapped;
			if (apbSetup) begin
				prdata <= pwrite ? '0 : rdMux;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrlDcs <= 1'b0;
			goReq   <= 1'b0;
			txField <= '0;
		end else begin
			goReq <= 1'b0;
			if (apbAccess && pwrite) begin
				if (paddr == `FC_A_CTRL) begin
					ctrlDcs <= pwdata[`FC_CTRL_DCS];
					goReq   <= pwdata[`FC_CTRL_GO] && !txActive;
				end
				if (paddr == `FC_A_TXFLD) begin
					txField <= pwdata[`FC_FLD_W-1:0];
				end
			end
		end
	end

	// ---- checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	sequence sSetup;
		psel && !penable;
	endsequence

	sequence sStart;
		txState == TX_IDLE && goReq;
	endsequence

	apb_answer_a: assert property (sSetup |=> pready)
		else $error("no ready after setup");
	tx_dis_id_a: assert property (sStart and !ctrlDcs |=> txActive && txShift[FW-1:`FC_FLD_W] == `FC_ID_DIS)
		else $error("bad DIS code sent");
	tx_dcs_id_a: assert property (sStart and ctrlDcs |=> txActive && txShift[FW-1:`FC_FLD_W] == `FC_ID_DCS)
		else $error("bad DCS code sent");
	tx_rsv_zero_a: assert property ($rose(txActive) |-> (txShiftFld & `FC_RSV_BITS) == '0)
		else $error("reserved bit sent nonzero");
	bit_spacing_a: assert property (bitTick |=> !bitTick [*8])
		else $error("bit ticks too close");
	bit_stable_a: assert property (txActive && !bitTick |=> $stable(txBit))
		else $error("bit changed mid bit time");
	id_only_a: assert property ((rxState == RX_HUNT && take && rxCnt == `FC_LEFT_W'(`FC_ID_W-1)
		&& hdrKind == FK_OTHER && rxFrame) |=> rxState == RX_HOLD && !rxReady)
		else $error("plain frame not closed after code");
	dcs_care_a: assert property ((rxState == RX_HUNT && take && rxCnt == `FC_LEFT_W'(`FC_ID_W-1)
		&& hdrId[6:0] == 7'(`FC_ID_DCS & `FC_DCS_CARE) && rxFrame) |=> rxState == RX_FIELD)
		else $error("DCS code not matched");
	err_hold_a: assert property (fieldDone && rxErr |=> $stable(modeWidth) && $stable(modeLength)
		&& $stable(capFlags) && errSticky)
		else $error("invalid field applied");
	dcs_apply_a: assert property (fieldDone && !rxErr && rxKind == FK_DCS
		|=> modeValid && modeWidth == $past(rxWidth) && modeLength == $past(rxLength))
		else $error("DCS mode not applied");
endmodule // fcfc_codec
`default_nettype wire

// *** core/fcfc_cfg.svh ***
`ifndef FCFC_CFG_SVH
`define FCFC_CFG_SVH
`define FC_CLK_HZ    50000000
`define FC_BAUD      300
`define FC_TONE0_HZ  1850
`define FC_TONE1_HZ  1650
`define FC_CNT_W     18
`define FC_ID_W      8
`define FC_FLD_W     20
`define FC_FRM_W     28
`define FC_LEFT_W    5
`define FC_ID_DIS    8'h01
`define FC_ID_DCS    8'h41
`define FC_DCS_CARE  8'h7f
`define FC_RSV_BITS  20'h030e0
`define FC_FB_T4RX   9
`define FC_FB_RATE   10
`define FC_FB_FINE   14
`define FC_FB_2D     15
`define FC_FB_WIDTH  16
`define FC_FB_LEN    18
`define FC_CODE_BAD  2'h3
`define FC_A_CTRL    8'h00
`define FC_A_TXFLD   8'h04
`define FC_A_STAT    8'h08
`define FC_A_RXFIFO  8'h0c
`define FC_A_MODE    8'h10
`define FC_A_RCAP    8'h14
`define FC_CTRL_GO   0
`define FC_CTRL_DCS  1
`define FC_ST_BUSY   0
`define FC_ST_AVAIL  1
`define FC_ST_ERR    2
`define FC_ST_LVL    4
`define FC_E_W       31
`define FC_E_VALID   31
`define FC_FIFO_D    4
`endif

// *** core/fcfc_pkg.sv ***
`default_nettype none
package fcfc_pkg;
	typedef enum logic [1:0] {FK_OTHER, FK_DIS, FK_DCS} fcfc_kind_t;
	typedef enum logic {TX_IDLE, TX_SEND} fcfc_tx_t;
	typedef enum logic [1:0] {RX_HUNT, RX_FIELD, RX_HOLD} fcfc_rx_t;
endpackage
`default_nettype wire

// *** test/fcfc_remote_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fcfc_remote_model #(
	parameter int BIT_CYCLES = 16
) (
	input  wire logic        mclk,
	input  wire logic        txFsk,
	input  wire logic        txBit,
	input  wire logic        txActive,
	input  wire logic        rxReady,
	output logic             rxBit,
	output logic             rxValid,
	output logic             rxFrame,
	output logic [27:0]      heard,
	output var int           heardCnt,
	output var int           halfLen0,
	output var int           halfLen1
);
	int   ph;
	int   run;
	logic fskQ;

	initial begin
		rxBit = 1'b0;
		rxValid = 1'b0;
		rxFrame = 1'b0;
	end

	// sample each sent bit mid bit time
	always @(posedge mclk) begin
		ph <= txActive ? ph + 1 : 0;
		if (txActive && ph == 0)
			heardCnt <= 0;
		if (txActive && ph % BIT_CYCLES == BIT_CYCLES / 2) begin
			heard <= {heard[26:0], txBit};
			heardCnt <= heardCnt + 1;
		end
	end

	// tone half periods, last clean one per bit value wins
	always @(posedge mclk) begin
		fskQ <= txFsk;
		run <= (txFsk != fskQ) ? 1 : run + 1;
		if (txActive && txFsk != fskQ && txBit)
			halfLen1 <= run;
		if (txActive && txFsk != fskQ && !txBit)
			halfLen0 <= run;
	end

	// code msb first, then field bit 1 upward
	task automatic sendFrame(input logic [7:0] code, input logic [19:0] fld, input int nb);
		for (int k = 0; k < nb; k++) begin
			rxBit <= (k < 8) ? code[7 - k] : fld[k - 8];
			rxValid <= 1'b1;
			rxFrame <= 1'b1;
			@(posedge mclk);
			while (rxReady !== 1'b1)
				@(posedge mclk);
		end
		rxValid <= 1'b0;
		rxFrame <= 1'b0;
		rxBit <= ~rxBit;
		@(posedge mclk);
	endtask
endmodule // fcfc_remote_model
`default_nettype wire

// *** test/test_fcfc_codec.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errCount++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module test_fcfc_codec;
	localparam logic [19:0] RSV = 20'h030e0;
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        txFsk;
	logic        txBit;
	logic        txActive;
	logic        rxBit;
	logic        rxValid;
	logic        rxFrame;
	logic        rxReady;
	logic [1:0]  modeRate;
	logic [19:0] capFlags;
	logic [27:0] heard;
	int          heardCnt;
	int          halfLen0;
	int          halfLen1;
	int          errCount = 0;
	int          comparisons = 0;
	logic [31:0] rd;
	logic        se;
	logic [19:0] fld;

	always #10 mclk = ~mclk;

	fcfc_codec #(.BIT_CYCLES(16), .HALF0(4), .HALF1(5), .FIFO_D(4)) u_dut (
		.mclk(mclk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txFsk(txFsk),
		.txBit(txBit), .txActive(txActive), .rxBit(rxBit), .rxValid(rxValid), .rxFrame(rxFrame),
		.rxReady(rxReady), .modeRate(modeRate), .modeWidth(), .modeLength(), .modeFine(),
		.mode2d(), .modeT4Rx(), .modeValid(), .capFlags(capFlags));

	fcfc_remote_model #(.BIT_CYCLES(16)) u_remote (
		.mclk(mclk), .txFsk(txFsk), .txBit(txBit), .txActive(txActive), .rxReady(rxReady),
		.rxBit(rxBit), .rxValid(rxValid), .rxFrame(rxFrame), .heard(heard), .heardCnt(heardCnt),
		.halfLen0(halfLen0), .halfLen1(halfLen1));

	task automatic summarize();
		$display("comparisons %0d errors %0d", comparisons, errCount);
		if (errCount == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			errCount++;
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic chkRd(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(a, 1'b0, 32'h0);
		`CHK(nm, e, rd)
	endtask

	// reserved field positions are not compared in queue entries
	task automatic popChk(input logic [31:0] e);
		repeat (4) @(posedge mclk);
		apb(8'h0c, 1'b0, 32'h0);
		`CHK("rxEntry", e & ~{4'h0, RSV, 8'h00}, rd & ~{4'h0, RSV, 8'h00})
	endtask

	task automatic sendTx(input logic [31:0] ctl);
		int n;
		apb(8'h00, 1'b1, ctl);
		n = 0;
		while (txActive !== 1'b1 && n < 20) begin
			@(posedge mclk);
			n++;
		end
		apb(8'h00, 1'b1, ctl);
		while (txActive !== 1'b0 && n < 600) begin
			@(posedge mclk);
			n++;
		end
		repeat (4) @(posedge mclk);
		`CHK("goIgnored", 1'b0, txActive)
	endtask

	function automatic logic [31:0] ent(input logic [7:0] c, input logic [1:0] k, input logic v, input logic [19:0] f);
		return {1'b1, v, k, f, c};
	endfunction

	// expected serial word as heard: code, then field bit 1 first
	function automatic logic [27:0] txw(input logic [7:0] c, input logic [19:0] f);
		for (int i = 0; i < 20; i++)
			txw[19 - i] = f[i] & ~RSV[i];
		txw[27:20] = c;
	endfunction

	initial begin
		repeat (20000) @(posedge mclk);
		errCount++;
		summarize();
	end

	initial begin
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		`CHK("rxReady", 1'b1, rxReady)
		chkRd(8'h08, 32'h0, "stat");
		chkRd(8'h10, 32'h0, "mode");
		chkRd(8'h14, 32'h0, "rcap");
		apb(8'h18, 1'b0, 32'h0);
		`CHK("slverr", 1'b1, se)
		`CHK("unmapped", 32'h0, rd)
		apb(8'h04, 1'b1, 32'h000fffff);
		chkRd(8'h04, 32'h000fffff, "txfield");
		sendTx(32'h1);
		`CHK("disTx", txw(8'h01, 20'hfffff), heard)
		`CHK("bitCount", 28, heardCnt)
		`CHK("half0", 4, halfLen0)
		`CHK("half1", 5, halfLen1)
		apb(8'h04, 1'b1, 32'h000a5a5);
		sendTx(32'h3);
		`CHK("dcsTx", txw(8'h41, 20'h0a5a5), heard)
		u_remote.sendFrame(8'h01, 20'h2ffff, 28);
		popChk(ent(8'h01, 2'd1, 1'b0, 20'h2ffff));
		`CHK("capFlags", 20'h2cf1f, capFlags)
		chkRd(8'h14, 32'h0002cf1f, "rcap");
		for (int r = 0; r < 4; r++) begin
			fld = 20'h9c200 | (20'(r[1]) << 10) | (20'(r[0]) << 11);
			u_remote.sendFrame(r[0] ? 8'hc1 : 8'h41, fld, 28);
			popChk(ent(r[0] ? 8'hc1 : 8'h41, 2'd2, 1'b0, fld));
			chkRd(8'h10, {22'h0, 8'hf6, 2'(r)}, "mode");
			`CHK("modeRate", 2'(r), modeRate)
		end
		u_remote.sendFrame(8'h41, 20'h3c200, 28);
		popChk(ent(8'h41, 2'd2, 1'b1, 20'h3c200));
		chkRd(8'h10, {22'h0, 8'hf6, 2'h3}, "modeKept");
		apb(8'h08, 1'b0, 32'h0);
		`CHK("errSticky", 1'b1, rd[2])
		u_remote.sendFrame(8'h01, 20'hc0000, 28);
		popChk(ent(8'h01, 2'd1, 1'b1, 20'hc0000));
		chkRd(8'h14, 32'h0002cf1f, "rcapKept");
		apb(8'h08, 1'b1, 32'h4);
		chkRd(8'h08, 32'h0, "statClr");
		for (int c = 2; c < 7; c++)
			u_remote.sendFrame(8'(c), 20'h0, 8);
		repeat (3) @(posedge mclk);
		`CHK("rxStall", 1'b0, rxReady)
		chkRd(8'h08, 32'h42, "statFull");
		for (int c = 2; c < 7; c++)
			popChk(ent(8'(c), 2'd0, 1'b0, 20'h0));
		chkRd(8'h0c, 32'h0, "empty");
		summarize();
	end
endmodule // test_fcfc_codec
`default_nettype wire
